// ===== inc/cses_pkg.sv
// constants and types for the sdo abort, emergency and sync block
package cses_pkg;
	localparam logic [10:0] CSES_ID_EMCY_BASE  = 11'h080;
	localparam logic [10:0] CSES_ID_SDO_TX     = 11'h580;
	localparam logic [10:0] CSES_ID_SYNC_DEF   = 11'h080;
	localparam logic [7:0]  CSES_CS_ABORT      = 8'h80;
	localparam logic [3:0]  CSES_EMCY_DLC      = 4'h8;
	localparam logic [3:0]  CSES_SDO_DLC       = 4'h8;
	localparam logic [3:0]  CSES_SYNC_DLC      = 4'h0;
	localparam int          CSES_NPDO          = 4;
	localparam int          CSES_NERR          = 10;

	// abort reason select codes
	typedef enum logic [4:0] {
		CSES_AB_TOGGLE   = 5'h00,
		CSES_AB_CMD      = 5'h01,
		CSES_AB_ACC_UNS  = 5'h02,
		CSES_AB_RD_WO    = 5'h03,
		CSES_AB_WR_RO    = 5'h04,
		CSES_AB_NO_OBJ   = 5'h05,
		CSES_AB_MAP_NO   = 5'h06,
		CSES_AB_MAP_LEN  = 5'h07,
		CSES_AB_PAR_INC  = 5'h08,
		CSES_AB_INT_INC  = 5'h09,
		CSES_AB_LEN      = 5'h0A,
		CSES_AB_LEN_HI   = 5'h0B,
		CSES_AB_LEN_LO   = 5'h0C,
		CSES_AB_NO_SUB   = 5'h0D,
		CSES_AB_RANGE    = 5'h0E,
		CSES_AB_RNG_HI   = 5'h0F,
		CSES_AB_RNG_LO   = 5'h10,
		CSES_AB_MAX_MIN  = 5'h11,
		CSES_AB_GENERAL  = 5'h12,
		CSES_AB_NO_ACC   = 5'h13,
		CSES_AB_NO_STATE = 5'h14
	} cses_abort_t;

	// emergency event index, one per input bit
	localparam int CSES_EV_OVERCUR = 0;
	localparam int CSES_EV_OVERRUN = 1;
	localparam int CSES_EV_PASSIVE = 2;
	localparam int CSES_EV_GUARD   = 3;
	localparam int CSES_EV_BUSOFF  = 4;
	localparam int CSES_EV_PDO_DIS = 5;
	localparam int CSES_EV_PDO_LEN = 6;
	localparam int CSES_EV_DEV     = 7;
	localparam int CSES_EV_DEV_POS = 8;
	localparam int CSES_EV_CLEAR   = 9;

	localparam logic [15:0] CSES_EC_NONE    = 16'h0000;
	localparam logic [15:0] CSES_EC_OVERCUR = 16'h2310;
	localparam logic [15:0] CSES_EC_OVERRUN = 16'h8110;
	localparam logic [15:0] CSES_EC_PASSIVE = 16'h8120;
	localparam logic [15:0] CSES_EC_GUARD   = 16'h8130;
	localparam logic [15:0] CSES_EC_BUSOFF  = 16'h8140;
	localparam logic [15:0] CSES_EC_PDO_DIS = 16'h8210;
	localparam logic [15:0] CSES_EC_PDO_LEN = 16'h8220;
	localparam logic [15:0] CSES_EC_DEV_VEL = 16'h8611;
	localparam logic [15:0] CSES_EC_DEV_POS = 16'h8400;

	localparam logic [15:0] CSES_MK_OVERCUR = 16'h0001;
	localparam logic [15:0] CSES_MK_DEV     = 16'h0002;
	localparam logic [15:0] CSES_MK_PASSIVE = 16'h0040;
	localparam logic [15:0] CSES_MK_OVERRUN = 16'h0080;
	localparam logic [15:0] CSES_MK_GUARD   = 16'h0100;
	localparam logic [15:0] CSES_MK_BUSOFF  = 16'h0200;
	localparam logic [15:0] CSES_MK_PDO_LEN = 16'h2000;
	localparam logic [15:0] CSES_MK_PDO_DIS = 16'h4000;

	localparam int CSES_ER_CURRENT = 1;
	localparam int CSES_ER_COMM    = 4;
	localparam int CSES_ER_DEVICE  = 5;
	localparam logic [7:0] CSES_ER_RESET = 8'h00;
	localparam logic [15:0] CSES_MASK_RESET = 16'hFFFF;

	// transmission types counted as synchronous
	localparam logic [7:0] CSES_TT_SYNC_LO = 8'h00;
	localparam logic [7:0] CSES_TT_SYNC_HI = 8'hF0;

	// delay time unit and rate
	localparam int CSES_CLK_HZ    = 50_000_000;
	localparam int CSES_TICK_US   = 1000;
	localparam int CSES_TICK_CYC  = CSES_CLK_HZ / 1_000_000 * CSES_TICK_US;
endpackage : cses_pkg

// ===== verilog/cses_abort_enc.sv
// abort code encoder: reason select to class, code, additional code
`timescale 1ns/1ps
`default_nettype none
module cses_abort_enc
	import cses_pkg::*;
(
	input  wire logic [4:0]  i_sel,
	output logic      [7:0]  o_class,
	output logic      [7:0]  o_code,
	output logic      [15:0] o_addl
);
	logic [31:0] ab_word;

	// lookup of class, code and additional code as one word
	always_comb begin
		ab_word = 32'h08000000;
		case (cses_abort_t'(i_sel))
			CSES_AB_TOGGLE:   ab_word = 32'h05030000;
			CSES_AB_CMD:      ab_word = 32'h05040001;
			CSES_AB_ACC_UNS:  ab_word = 32'h06010000;
			CSES_AB_RD_WO:    ab_word = 32'h06010001;
			CSES_AB_WR_RO:    ab_word = 32'h06010002;
			CSES_AB_NO_OBJ:   ab_word = 32'h06020000;
			CSES_AB_NO_SUB:   ab_word = 32'h06090011;
			CSES_AB_LEN:      ab_word = 32'h06070010;
			CSES_AB_LEN_HI:   ab_word = 32'h06070012;
			CSES_AB_LEN_LO:   ab_word = 32'h06070013;
			CSES_AB_RANGE:    ab_word = 32'h06090030;
			CSES_AB_RNG_HI:   ab_word = 32'h06090031;
			CSES_AB_RNG_LO:   ab_word = 32'h06090032;
			CSES_AB_MAX_MIN:  ab_word = 32'h06090036;
			CSES_AB_MAP_NO:   ab_word = 32'h06040041;
			CSES_AB_MAP_LEN:  ab_word = 32'h06040042;
			CSES_AB_PAR_INC:  ab_word = 32'h06040043;
			CSES_AB_INT_INC:  ab_word = 32'h06040047;
			CSES_AB_GENERAL:  ab_word = 32'h08000000;
			CSES_AB_NO_ACC:   ab_word = 32'h08000020;
			CSES_AB_NO_STATE: ab_word = 32'h08000022;
			default:          ab_word = 32'h08000000; // unknown: general error
		endcase
	end

	// split into the three abort fields
	assign o_class = ab_word[31:24];
	assign o_code  = ab_word[23:16];
	assign o_addl  = ab_word[15:0];
endmodule : cses_abort_enc
`default_nettype wire

// ===== verilog/cses_top.sv
// sdo abort, emergency composer and sync receiver of a can node
`timescale 1ns/1ps
`default_nettype none
module cses_top
	import cses_pkg::*;
#(
	parameter int NPDO = CSES_NPDO
)(
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic [6:0]         i_node_id,
	// sdo abort request
	input  wire logic               i_sdo_abort,
	input  wire logic [4:0]         i_abort_sel,
	input  wire logic [15:0]        i_sdo_index,
	input  wire logic [7:0]         i_sdo_subindex,
	// emergency configuration and events
	input  wire logic [15:0]        i_emcy_mask,
	input  wire logic [15:0]        i_vendor_fault,
	input  wire logic [CSES_NERR-1:0] i_err_evt,
	input  wire logic               i_overcur,
	input  wire logic [15:0]        i_err_delay,
	// sync configuration and reception
	input  wire logic [10:0]        i_sync_id,
	input  wire logic               i_sync_id_set,
	input  wire logic               i_rx_valid,
	input  wire logic [10:0]        i_rx_id,
	input  wire logic [3:0]         i_rx_dlc,
	input  wire logic [8*NPDO-1:0]  i_pdo_ttype,
	// transmit frame port
	input  wire logic               i_tx_ready,
	output logic                    o_tx_valid,
	output logic      [10:0]        o_tx_id,
	output logic      [3:0]         o_tx_dlc,
	output logic      [63:0]        o_tx_data,
	// status
	output logic      [7:0]         o_err_reg,
	output logic      [15:0]        o_last_code,
	output logic      [NPDO-1:0]    o_pdo_trig,
	output logic      [10:0]        o_sync_id
);
	// elaboration check: trigger vector serves 1 to 16 pdos
	if (NPDO < 1 || NPDO > 16) begin : g_bad_npdo
		$error("cses_top: NPDO out of range");
	end

	typedef enum logic [1:0] {
		CSES_ST_IDLE  = 2'b00,
		CSES_ST_ABORT = 2'b01,
		CSES_ST_EMCY  = 2'b10
	} cses_st_t;

	typedef struct packed {
		cses_st_t        st;
		logic            tx_valid;
		logic [10:0]     tx_id;
		logic [3:0]      tx_dlc;
		logic [63:0]     tx_data;
		logic [7:0]      err_reg;
		logic [15:0]     last_code;
		logic [NPDO-1:0] pdo_trig;
		logic [10:0]     sync_id;
		logic [CSES_NERR-1:0] pend;
		logic            ab_pend;
		logic [63:0]     ab_data;
		logic [15:0]     tick_cnt;
		logic [15:0]     delay_cnt;
		logic            oc_sent;
	} cses_state_t;

	cses_state_t s_r;
	cses_state_t s_nxt;

	logic [7:0]  ab_class;
	logic [7:0]  ab_code;
	logic [15:0] ab_addl;
	logic        tick;
	logic        oc_fire;
	logic [15:0] ev_code [CSES_NERR];
	logic [15:0] ev_mask [CSES_NERR];
	logic [7:0]  ev_bit  [CSES_NERR];
	logic [CSES_NERR-1:0] ev_all;
	logic [NPDO-1:0] pdo_sync;
	logic        sync_hit;
	logic        tx_take;
	logic [10:0] sdo_id;
	logic [10:0] emcy_id;

	cses_abort_enc u_enc (
		.i_sel   (i_abort_sel),
		.o_class (ab_class),
		.o_code  (ab_code),
		.o_addl  (ab_addl)
	);

	// event tables: code, mask bit and error register bit
	always_comb begin
		for (int k = 0; k < CSES_NERR; k++) begin
			ev_code[k] = CSES_EC_NONE;
			ev_mask[k] = 16'h0000;
			ev_bit[k]  = 8'h00;
		end
		ev_code[CSES_EV_OVERCUR] = CSES_EC_OVERCUR;
		ev_mask[CSES_EV_OVERCUR] = CSES_MK_OVERCUR;
		ev_bit[CSES_EV_OVERCUR]  = 8'(1 << CSES_ER_CURRENT);
		// communication faults
		ev_code[CSES_EV_OVERRUN] = CSES_EC_OVERRUN;
		ev_mask[CSES_EV_OVERRUN] = CSES_MK_OVERRUN;
		ev_code[CSES_EV_PASSIVE] = CSES_EC_PASSIVE;
		ev_mask[CSES_EV_PASSIVE] = CSES_MK_PASSIVE;
		ev_code[CSES_EV_GUARD]   = CSES_EC_GUARD;
		ev_mask[CSES_EV_GUARD]   = CSES_MK_GUARD;
		ev_code[CSES_EV_BUSOFF]  = CSES_EC_BUSOFF;
		ev_mask[CSES_EV_BUSOFF]  = CSES_MK_BUSOFF;
		// pdo length faults
		ev_code[CSES_EV_PDO_DIS] = CSES_EC_PDO_DIS;
		ev_mask[CSES_EV_PDO_DIS] = CSES_MK_PDO_DIS;
		ev_code[CSES_EV_PDO_LEN] = CSES_EC_PDO_LEN;
		ev_mask[CSES_EV_PDO_LEN] = CSES_MK_PDO_LEN;
		for (int k = CSES_EV_OVERRUN; k <= CSES_EV_PDO_LEN; k++)
			ev_bit[k] = 8'(1 << CSES_ER_COMM);
		// speed deviation, velocity and position mode
		ev_code[CSES_EV_DEV]     = CSES_EC_DEV_VEL;
		ev_mask[CSES_EV_DEV]     = CSES_MK_DEV;
		ev_bit[CSES_EV_DEV]      = 8'(1 << CSES_ER_DEVICE);
		ev_code[CSES_EV_DEV_POS] = CSES_EC_DEV_POS;
		ev_mask[CSES_EV_DEV_POS] = CSES_MK_DEV;
		ev_bit[CSES_EV_DEV_POS]  = 8'(1 << CSES_ER_DEVICE);
	end

	// millisecond tick for the overcurrent delay
	assign tick = (s_r.tick_cnt == 16'(CSES_TICK_CYC - 1));
	assign oc_fire = i_overcur && !s_r.oc_sent &&
		(s_r.delay_cnt >= i_err_delay) && tick;

	// incoming events, overcurrent is delay qualified
	always_comb begin
		ev_all = i_err_evt;
		ev_all[CSES_EV_OVERCUR] = oc_fire;
		ev_all[CSES_EV_CLEAR] = 1'b0;
	end

	// per pdo sync qualification
	generate
		for (genvar g = 0; g < NPDO; g++) begin : g_pdo
			assign pdo_sync[g] =
				(i_pdo_ttype[8*g +: 8] >= CSES_TT_SYNC_LO) &&
				(i_pdo_ttype[8*g +: 8] <= CSES_TT_SYNC_HI);
		end
	endgenerate

	assign sync_hit = i_rx_valid && (i_rx_id == s_r.sync_id) &&
		(i_rx_dlc == CSES_SYNC_DLC);

	// frame handed to the transmitter at this edge
	assign tx_take = s_r.tx_valid && i_tx_ready;

	// own identifiers: function base plus node id
	assign sdo_id  = 11'(CSES_ID_SDO_TX + 11'(i_node_id));
	assign emcy_id = 11'(CSES_ID_EMCY_BASE + 11'(i_node_id));

	// next state
	always_comb begin
		logic [CSES_NERR-1:0] pend;
		logic [CSES_NERR-1:0] fresh;
		logic found;
		s_nxt = s_r;
		pend  = s_r.pend;
		fresh = '0;
		found = 1'b0;
		s_nxt.pdo_trig = '0;
		s_nxt.tick_cnt = tick ? 16'h0000 : 16'(s_r.tick_cnt + 16'h0001);
		// overcurrent duration counter
		if (!i_overcur) begin
			s_nxt.delay_cnt = 16'h0000;
			s_nxt.oc_sent   = 1'b0;
		end else if (tick && s_r.delay_cnt != 16'hFFFF) begin
			s_nxt.delay_cnt = 16'(s_r.delay_cnt + 16'h0001);
		end
		if (oc_fire)
			s_nxt.oc_sent = 1'b1;
		// sync id configuration
		if (i_sync_id_set)
			s_nxt.sync_id = i_sync_id;
		if (sync_hit)
			s_nxt.pdo_trig = pdo_sync;
		// deviation cleared by state change or new positioning
		if (i_err_evt[CSES_EV_CLEAR])
			s_nxt.err_reg[CSES_ER_DEVICE] = 1'b0;

		// latch abort request as a complete frame, byte 0 lowest
		if (i_sdo_abort && !s_r.ab_pend) begin
			s_nxt.ab_pend = 1'b1;
			s_nxt.ab_data = {
				ab_class,
				ab_code,
				ab_addl[7:0],
				ab_addl[15:8],
				i_sdo_subindex,
				i_sdo_index[15:8],
				i_sdo_index[7:0],
				CSES_CS_ABORT
			};
		end

		// masked events set pending and error register bits
		for (int k = 0; k < CSES_NERR; k++) begin
			if (ev_all[k] && (i_emcy_mask & ev_mask[k]) != 16'h0000) begin
				fresh[k] = 1'b1;
				s_nxt.err_reg = s_nxt.err_reg | ev_bit[k];
			end
		end

		// frame taken: offer drops for at least one cycle
		if (tx_take)
			s_nxt.tx_valid = 1'b0;

		// transmitter: abort first, then emergencies in index order
		case (s_r.st)
			CSES_ST_IDLE: begin
				if (s_r.ab_pend) begin
					s_nxt.st       = CSES_ST_ABORT;
					s_nxt.tx_valid = 1'b1;
					s_nxt.tx_id    = sdo_id;
					s_nxt.tx_dlc   = CSES_SDO_DLC;
					s_nxt.tx_data  = s_r.ab_data;
				end else begin
					for (int k = 0; k < CSES_NERR; k++) begin
						if (s_r.pend[k] && !found) begin
							found    = 1'b1;
							pend[k]  = 1'b0;
							s_nxt.st       = CSES_ST_EMCY;
							s_nxt.tx_valid = 1'b1;
							s_nxt.tx_id    = emcy_id;
							s_nxt.tx_dlc   = CSES_EMCY_DLC;
							s_nxt.tx_data  = {
								24'h000000,
								i_vendor_fault[15:8],
								i_vendor_fault[7:0],
								s_nxt.err_reg,
								ev_code[k][15:8],
								ev_code[k][7:0]
							};
							s_nxt.last_code = ev_code[k];
						end
					end
				end
			end
			CSES_ST_ABORT: begin
				if (tx_take) begin
					s_nxt.st      = CSES_ST_IDLE;
					s_nxt.ab_pend = 1'b0;
				end
			end
			CSES_ST_EMCY: begin
				if (tx_take)
					s_nxt.st = CSES_ST_IDLE;
			end
			default: s_nxt.st = CSES_ST_IDLE;
		endcase

		// an event arriving as its frame is picked stays pending
		s_nxt.pend = pend | fresh;
	end

	// state register, every field to its reset value
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_r.st        <= CSES_ST_IDLE;
			s_r.tx_valid  <= 1'b0;
			s_r.tx_id     <= 11'h000;
			s_r.tx_dlc    <= 4'h0;
			s_r.tx_data   <= 64'h0000000000000000;
			s_r.err_reg   <= CSES_ER_RESET;
			s_r.last_code <= CSES_EC_NONE;
			s_r.pdo_trig  <= '0;
			s_r.sync_id   <= CSES_ID_SYNC_DEF;
			s_r.pend      <= '0;
			s_r.ab_pend   <= 1'b0;
			s_r.ab_data   <= 64'h0000000000000000;
			s_r.tick_cnt  <= 16'h0000;
			s_r.delay_cnt <= 16'h0000;
			s_r.oc_sent   <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign o_tx_valid  = s_r.tx_valid;
	assign o_tx_id     = s_r.tx_id;
	assign o_tx_dlc    = s_r.tx_dlc;
	assign o_tx_data   = s_r.tx_data;
	assign o_err_reg   = s_r.err_reg;
	assign o_last_code = s_r.last_code;
	assign o_pdo_trig  = s_r.pdo_trig;
	assign o_sync_id   = s_r.sync_id;
endmodule : cses_top
`default_nettype wire

// ===== sim/cses_chk_assertions.sv
// concurrent checks on the ports of the abort, emergency and sync block
`timescale 1ns/1ps
`default_nettype none
module cses_chk
	import cses_pkg::*;
#(
	parameter int NPDO = CSES_NPDO
)(
	input wire logic                i_clk,
	input wire logic                i_nrst,
	input wire logic [6:0]          i_node_id,
	input wire logic                i_sdo_abort,
	input wire logic [15:0]         i_emcy_mask,
	input wire logic [CSES_NERR-1:0] i_err_evt,
	input wire logic [10:0]         i_sync_id,
	input wire logic                i_sync_id_set,
	input wire logic                i_rx_valid,
	input wire logic [10:0]         i_rx_id,
	input wire logic [3:0]          i_rx_dlc,
	input wire logic [8*NPDO-1:0]   i_pdo_ttype,
	input wire logic                i_tx_ready,
	input wire logic                o_tx_valid,
	input wire logic [10:0]         o_tx_id,
	input wire logic [3:0]          o_tx_dlc,
	input wire logic [63:0]         o_tx_data,
	input wire logic [7:0]          o_err_reg,
	input wire logic [NPDO-1:0]     o_pdo_trig,
	input wire logic [10:0]         o_sync_id
);
	logic [NPDO-1:0] sync_pdo;
	logic            hit;
	logic            is_abort;
	// pdos whose transmission type counts as synchronous
	always_comb begin
		for (int k = 0; k < NPDO; k++) begin
			sync_pdo[k] = i_pdo_ttype[8*k+:8] <= CSES_TT_SYNC_HI;
		end
	end
	assign hit = i_rx_valid && i_rx_id == o_sync_id && i_rx_dlc == 4'h0;
	assign is_abort = o_tx_valid && o_tx_data[7:0] == 8'h80;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	abort_frame_a: assert property (is_abort |->
		o_tx_id == 11'h580 + {4'h0, i_node_id} && o_tx_dlc == 4'h8)
		else $error("abort frame id or length wrong");
	abort_class_a: assert property (is_abort |->
		o_tx_data[63:56] inside {8'h05, 8'h06, 8'h08})
		else $error("abort class out of set");
	emcy_pad_a: assert property (o_tx_valid &&
		o_tx_id == 11'h080 + {4'h0, i_node_id} |->
		o_tx_data[63:40] == 24'h0 && o_tx_dlc == 4'h8)
		else $error("emergency padding or length wrong");
	tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
		o_tx_valid && $stable(o_tx_data) && $stable(o_tx_id))
		else $error("offered frame changed before accept");
	abort_lat_a: assert property ($rose(i_sdo_abort) &&
		!o_tx_valid |-> ##2 is_abort)
		else $error("abort frame not offered in time");
	sync_trig_a: assert property (hit |=>
		o_pdo_trig == $past(sync_pdo))
		else $error("sync trigger pattern wrong");
	sync_quiet_a: assert property (!hit |=> o_pdo_trig == '0)
		else $error("trigger without sync");
	sync_load_a: assert property (i_sync_id_set |=>
		o_sync_id == $past(i_sync_id))
		else $error("sync id not loaded");
	comm_bit_a: assert property (i_err_evt[CSES_EV_OVERRUN] &&
		i_emcy_mask[7] |-> ##[1:2] o_err_reg[CSES_ER_COMM])
		else $error("comm bit not set");
endmodule : cses_chk
bind cses_top cses_chk #(.NPDO(NPDO)) u_chk (.*);
`default_nettype wire

// ===== sim/cses_master_model.sv
// bus master model: accepts frames with stall, sends sync frames
`timescale 1ns/1ps
`default_nettype none
module cses_master_model (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_tx_valid,
	input  wire logic [10:0] i_tx_id,
	input  wire logic [3:0]  i_tx_dlc,
	input  wire logic [63:0] i_tx_data,
	input  wire logic [3:0]  i_stall,
	input  wire logic        i_sync_go,
	input  wire logic [10:0] i_sync_to,
	input  wire logic [3:0]  i_sync_dlc,
	output logic             o_tx_ready,
	output logic             o_rx_valid,
	output logic [10:0]      o_rx_id,
	output logic [3:0]       o_rx_dlc,
	output logic [31:0]      o_cnt,
	output logic [10:0]      o_id,
	output logic [3:0]       o_dlc,
	output logic [63:0]      o_data
);
	logic [4:0] wait_r;
	logic       go_r;
	// capture accepted frames, count stall cycles
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cnt <= '0;
			wait_r <= '0;
			go_r <= 1'b0;
		end else begin
			go_r <= i_sync_go;
			if (i_tx_valid && o_tx_ready) begin
				o_cnt <= o_cnt + 1;
				o_id <= i_tx_id;
				o_dlc <= i_tx_dlc;
				o_data <= i_tx_data;
				wait_r <= '0;
			end else if (i_tx_valid && !wait_r[4]) begin
				wait_r <= wait_r + 1;
			end
		end
	end
	// drive on the falling edge; idle id toggles so a stale value never holds for two cycles in a row
	always @(negedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_tx_ready <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_id <= 11'h7FF;
			o_rx_dlc <= 4'hF;
		end else begin
			o_tx_ready <= i_tx_valid && wait_r >= {1'b0, i_stall};
			o_rx_valid <= go_r;
			o_rx_id <= go_r ? i_sync_to : ~o_rx_id;
			o_rx_dlc <= go_r ? i_sync_dlc : ~o_rx_dlc;
		end
	end
endmodule : cses_master_model
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the abort, emergency and sync block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cses_pkg::*;
	logic        clk, nrst, abrt, oc, sset, go, tv, rdy, rv;
	logic [4:0]  sel;
	logic [15:0] idx, mask, vf, dly, lc;
	logic [7:0]  sub, er, exp_er;
	logic [9:0]  evt;
	logic [10:0] sid, sto, tid, rid, oid, mid;
	logic [3:0]  sdl, stall, tdl, rdl, trig, mdl, seen;
	logic [63:0] td, md;
	logic [31:0] mcnt, c0, tt;
	logic [31:0] ttab [0:21];
	int          fail_count, total_checks;
	cses_top i_dut (.i_clk(clk), .i_nrst(nrst), .i_node_id(7'h15),
		.i_sdo_abort(abrt), .i_abort_sel(sel), .i_sdo_index(idx),
		.i_sdo_subindex(sub), .i_emcy_mask(mask), .i_vendor_fault(vf),
		.i_err_evt(evt), .i_overcur(oc), .i_err_delay(dly),
		.i_sync_id(sid), .i_sync_id_set(sset), .i_rx_valid(rv),
		.i_rx_id(rid), .i_rx_dlc(rdl), .i_pdo_ttype(tt),
		.i_tx_ready(rdy), .o_tx_valid(tv), .o_tx_id(tid), .o_tx_dlc(tdl),
		.o_tx_data(td), .o_err_reg(er), .o_last_code(lc),
		.o_pdo_trig(trig), .o_sync_id(oid));
	cses_master_model i_master (.i_clk(clk), .i_nrst(nrst),
		.i_tx_valid(tv), .i_tx_id(tid), .i_tx_dlc(tdl), .i_tx_data(td),
		.i_stall(stall), .i_sync_go(go), .i_sync_to(sto),
		.i_sync_dlc(sdl), .o_tx_ready(rdy), .o_rx_valid(rv),
		.o_rx_id(rid), .o_rx_dlc(rdl), .o_cnt(mcnt), .o_id(mid),
		.o_dlc(mdl), .o_data(md));
	task automatic check(input logic [63:0] s, e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t ns: saw %h want %h", $time, s, e);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	// bounded wait for the master to accept one frame
	task automatic wait_frame(input int lim);
		c0 = mcnt;
		for (int n = 0; n < lim && mcnt == c0; n++) @(negedge clk);
		if (mcnt == c0) begin
			fail_count++;
			$display("[FAIL] %0t ns: no frame", $time);
			end_of_test();
		end
	endtask : wait_frame
	task automatic quiet(input int cyc);
		c0 = mcnt;
		repeat (cyc) @(negedge clk);
		check(mcnt, c0);
	endtask : quiet
	// abort request, a refused second request, then the frame
	task automatic abort_case(input logic [4:0] s, input logic [31:0] e);
		@(negedge clk);
		abrt = 1'b1;
		sel = s;
		idx = {3'h5, s, 8'hC3};
		sub = {3'h0, s};
		stall = s[3:0];
		@(negedge clk);
		sel = 5'h00;
		@(negedge clk);
		abrt = 1'b0;
		wait_frame(40);
		check(mid, 11'h595);
		check(mdl, 4'h8);
		check(md, {e[31:16], e[7:0], e[15:8], sub, idx, 8'h80});
		quiet(6);
	endtask : abort_case
	// one event pulse, mask on or off, then frame or silence
	task automatic emcy_case(input int b, input logic [15:0] c, m,
			input int eb, input logic on);
		@(negedge clk);
		mask = on ? m : ~m;
		vf = {c[7:0], 8'h5A};
		evt = 10'(1) << b;
		@(negedge clk);
		evt = '0;
		if (!on) begin
			quiet(8);
			check(er, exp_er);
		end else begin
			exp_er[eb] = 1'b1;
			wait_frame(40);
			check(mid, 11'h095);
			check(mdl, 4'h8);
			check(md, {24'h0, vf, exp_er, c});
			check(lc, c);
		end
	endtask : emcy_case
	// one sync frame, collect triggers over a few edges
	task automatic sync_case(input logic [10:0] id, input logic [3:0] dl, e);
		@(negedge clk);
		sto = id;
		sdl = dl;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		seen = '0;
		repeat (4) begin
			@(posedge clk);
			#1 seen |= trig;
		end
		@(negedge clk);
		check(seen, e);
	endtask : sync_case
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{nrst, abrt, oc, sset, go, sel, idx, sub, evt, sid, sto} = '0;
		{mask, vf, dly, sdl, stall, exp_er} = '0;
		tt = 32'hF1F00100;
		ttab = '{32'h05030000, 32'h05040001, 32'h06010000, 32'h06010001,
			32'h06010002, 32'h06020000, 32'h06040041, 32'h06040042,
			32'h06040043, 32'h06040047, 32'h06070010, 32'h06070012,
			32'h06070013, 32'h06090011, 32'h06090030, 32'h06090031,
			32'h06090032, 32'h06090036, 32'h08000000, 32'h08000020,
			32'h08000022, 32'h08000000};
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		check(oid, 11'h080);
		check(er, 8'h00);
		check(tv, 1'b0);
		for (int i = 0; i < 22; i++)
			abort_case(i == 21 ? 5'h1F : 5'(i), ttab[i]);
		$display("abort tests done");
		emcy_case(1, 16'h8110, 16'h0080, 4, 1'b0);
		emcy_case(1, 16'h8110, 16'h0080, 4, 1'b1);
		emcy_case(2, 16'h8120, 16'h0040, 4, 1'b1);
		emcy_case(3, 16'h8130, 16'h0100, 4, 1'b1);
		emcy_case(4, 16'h8140, 16'h0200, 4, 1'b1);
		emcy_case(5, 16'h8210, 16'h4000, 4, 1'b1);
		emcy_case(6, 16'h8220, 16'h2000, 4, 1'b1);
		emcy_case(7, 16'h8611, 16'h0002, 5, 1'b0);
		emcy_case(7, 16'h8611, 16'h0002, 5, 1'b1);
		emcy_case(8, 16'h8400, 16'h0002, 5, 1'b1);
		evt = 10'h200;
		@(negedge clk);
		evt = '0;
		exp_er[5] = 1'b0;
		repeat (3) @(negedge clk);
		check(er, exp_er);
		mask = 16'h0001;
		oc = 1'b1;
		exp_er[1] = 1'b1;
		wait_frame(60000);
		oc = 1'b0;
		check(mid, 11'h095);
		check(md, {24'h0, vf, exp_er, 16'h2310});
		check(lc, 16'h2310);
		$display("emergency tests done");
		sync_case(11'h080, 4'h0, 4'h7);
		sync_case(11'h080, 4'h1, 4'h0);
		sid = 11'h123;
		sset = 1'b1;
		@(negedge clk);
		sset = 1'b0;
		@(negedge clk);
		check(oid, 11'h123);
		sync_case(11'h080, 4'h0, 4'h0);
		sync_case(11'h123, 4'h0, 4'h7);
		tt = 32'h00F1FF05;
		sync_case(11'h123, 4'h0, 4'h9);
		$display("sync tests done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
